// ==== fbn_node.sv ====
// fieldbus node application state machine with host start-up sequencing
// Overview of operation
// - after reset the node sits in init, code 01h, no mailbox or process data
// - init to preop 02h checks mailbox setup; preop allows mailbox only
// - preop to safeop 04h checks process-data channel setup
// - inputs copied to dual-port memory before safeop is acknowledged
// - safeop: mailbox and process data on, inputs updated, outputs off
// - op 08h: master output data drive physical outputs, mailbox and process data on, file access off
// - bootstrap 03h is reachable only from init
// - bootstrap allows only file-access mailbox, everything else off
// - code 00h means station absent, FFh means station not configured
// - only master requests change state; each upward step starts its service
// - downward steps stop the matching services
// - diagnostics with no request in the same cycle, and state-change errors, go to the master as emergencies
// - host in run requests op from all nodes, holds program start while any in safeop
// - host waits for mandatory nodes at most the monitoring time, then runs
`default_nettype none
module fbn_node
  import fbn_pkg::*;
#(
  parameter int IO_W = FBN_IO_W,
  parameter int MON_CYCLES = FBN_MON_CYCLES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire fbn_request_t req,
  input wire logic mbx_cfg_ok,
  input wire logic pd_cfg_ok,
  input wire logic station_present,
  input wire logic station_configured,
  input wire logic diag_event,
  input wire logic [7:0] diag_code,
  input wire logic [IO_W-1:0] phys_in,
  input wire logic [IO_W-1:0] master_out,
  input wire logic mandatory_ready,
  input wire logic any_safeop,
  output logic [7:0] state_code,
  output fbn_services_t services,
  output logic ack,
  output logic error,
  output fbn_emcy_t emcy,
  output logic [IO_W-1:0] dpm_in,
  output logic [IO_W-1:0] phys_out,
  output logic host_req_op,
  output logic main_program_run
);
  // refuse widths and monitoring times that the counters cannot serve
  if (IO_W < 1 || MON_CYCLES < 1)
  begin : gen_bad_params
    $error("fbn_node: bad parameters");
  end

  localparam int MW = $clog2(MON_CYCLES + 1);

  typedef struct packed {
    fbn_state_t st;
    logic ack;
    logic error;
    fbn_emcy_t emcy;
    logic [IO_W-1:0] dpm_in;
    logic [IO_W-1:0] phys_out;
    logic [1:0] pres_sync;
    logic [1:0] conf_sync;
    fbn_host_t hs;
    logic [MW-1:0] mon_cnt;
  } fbn_regs_t;

  fbn_regs_t state_reg;
  fbn_regs_t state_next;

  // map a state to its reported code
  function automatic logic [7:0] fbn_code(input fbn_state_t s);
    fbn_code = FBN_CODE_UNCONF; // unused encodings read as unconfigured
    unique case (s)
      FBN_ST_INIT: fbn_code = FBN_CODE_INIT;
      FBN_ST_PREOP: fbn_code = FBN_CODE_PREOP;
      FBN_ST_BOOT: fbn_code = FBN_CODE_BOOT;
      FBN_ST_SAFEOP: fbn_code = FBN_CODE_SAFEOP;
      FBN_ST_OP: fbn_code = FBN_CODE_OP;
    endcase
  endfunction : fbn_code

  // service enables per state, so each transition starts or stops services
  function automatic fbn_services_t fbn_svc(input fbn_state_t s);
    fbn_services_t v;
    v = '0;
    unique case (s)
      FBN_ST_INIT: v = '0;
      FBN_ST_PREOP: v.mailbox_en = 1'b1;
      FBN_ST_BOOT: v.file_access_en = 1'b1;
      FBN_ST_SAFEOP:
      begin
        v.mailbox_en = 1'b1;
        v.inputs_en = 1'b1;
      end
      FBN_ST_OP:
      begin
        v.mailbox_en = 1'b1;
        v.inputs_en = 1'b1;
        v.outputs_en = 1'b1;
      end
    endcase
    return v;
  endfunction : fbn_svc

  fbn_services_t svc;
  assign svc = fbn_svc(state_reg.st);

  // next-state logic for node, data paths and host sequencing
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.error = 1'b0;
    state_next.emcy = '0;
    // status inputs come from the bus side, so synchronise them
    state_next.pres_sync = {state_reg.pres_sync[0], station_present};
    state_next.conf_sync = {state_reg.conf_sync[0], station_configured};
    if (req.valid)
    begin
      state_next.ack = 1'b1;
      unique case ({state_reg.st, req.code}) inside
        {FBN_ST_INIT, FBN_CODE_PREOP}:
        begin
          if (mbx_cfg_ok)
            state_next.st = FBN_ST_PREOP;
          else
          begin
            state_next.ack = 1'b0;
            state_next.error = 1'b1;
            state_next.emcy = '{1'b1, FBN_EMCY_MBX_CFG, fbn_code(state_reg.st)};
          end
        end
        {FBN_ST_PREOP, FBN_CODE_SAFEOP}:
        begin
          if (pd_cfg_ok)
          begin
            state_next.st = FBN_ST_SAFEOP;
            state_next.dpm_in = phys_in;
          end
          else
          begin
            state_next.ack = 1'b0;
            state_next.error = 1'b1;
            state_next.emcy = '{1'b1, FBN_EMCY_PD_CFG, fbn_code(state_reg.st)};
          end
        end
        {FBN_ST_SAFEOP, FBN_CODE_OP}: state_next.st = FBN_ST_OP;
        {FBN_ST_INIT, FBN_CODE_BOOT}: state_next.st = FBN_ST_BOOT;
        {FBN_ST_PREOP, FBN_CODE_INIT}, {FBN_ST_SAFEOP, FBN_CODE_INIT},
        {FBN_ST_OP, FBN_CODE_INIT}, {FBN_ST_BOOT, FBN_CODE_INIT}:
          state_next.st = FBN_ST_INIT;
        {FBN_ST_SAFEOP, FBN_CODE_PREOP}, {FBN_ST_OP, FBN_CODE_PREOP}:
          state_next.st = FBN_ST_PREOP;
        {FBN_ST_OP, FBN_CODE_SAFEOP}: state_next.st = FBN_ST_SAFEOP;
        default:
        begin
          // same-state request is harmless and simply acknowledged
          if (req.code != fbn_code(state_reg.st))
          begin
            state_next.ack = 1'b0;
            state_next.error = 1'b1;
            state_next.emcy = '{1'b1, FBN_EMCY_ILLEGAL, fbn_code(state_reg.st)};
          end
        end
      endcase
    end
    else if (diag_event)
    begin
      state_next.emcy = '{1'b1, diag_code, fbn_code(state_reg.st)};
    end
    // cyclic input update while inputs are enabled
    if (svc.inputs_en && !(req.valid && state_next.st != state_reg.st))
      state_next.dpm_in = phys_in;
    if (state_next.st == FBN_ST_INIT || state_next.st == FBN_ST_BOOT)
      state_next.dpm_in = '0;
    // outputs follow the master only in op, otherwise held off
    state_next.phys_out = (state_next.st == FBN_ST_OP) ? master_out : '0;
    // host start-up sequencing
    unique case (state_reg.hs)
      FBN_HS_STARTUP:
      begin
        if (mandatory_ready || state_reg.mon_cnt == MW'(MON_CYCLES - 1))
          state_next.hs = FBN_HS_WAIT_OP;
        else
          state_next.mon_cnt = state_reg.mon_cnt + MW'(1);
      end
      FBN_HS_WAIT_OP:
      begin
        if (!any_safeop)
          state_next.hs = FBN_HS_RUN;
      end
      FBN_HS_RUN: state_next.hs = FBN_HS_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '0; // st is init
      state_reg.st <= FBN_ST_INIT;
      state_reg.hs <= FBN_HS_STARTUP;
    end
    else
      state_reg <= state_next;
  end

  // status code: absent and unconfigured stations override the state code
  always_comb
  begin
    if (!state_reg.pres_sync[1])
      state_code = FBN_CODE_ABSENT;
    else if (!state_reg.conf_sync[1])
      state_code = FBN_CODE_UNCONF;
    else
      state_code = fbn_code(state_reg.st);
  end

  assign services = svc;
  assign ack = state_reg.ack;
  assign error = state_reg.error;
  assign emcy = state_reg.emcy;
  assign dpm_in = state_reg.dpm_in;
  assign phys_out = state_reg.phys_out;
  assign host_req_op = (state_reg.hs != FBN_HS_STARTUP);
  assign main_program_run = (state_reg.hs == FBN_HS_RUN);

  sequence boot_req_s;
    req.valid && req.code == FBN_CODE_BOOT;
  endsequence

  reset_init_a: assert property (@(posedge clk) $rose(rstn) |-> state_reg.st == FBN_ST_INIT)
    else $error("not in init after reset");
  boot_only_init_a: assert property (@(posedge clk) disable iff (!rstn)
    boot_req_s and (state_reg.st != FBN_ST_INIT) |=> state_reg.st != FBN_ST_BOOT)
    else $error("boot entered from non-init");
  mbx_check_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.st == FBN_ST_INIT && req.valid && req.code == FBN_CODE_PREOP && !mbx_cfg_ok
    |=> state_reg.st == FBN_ST_INIT && error && emcy.valid)
    else $error("preop entered without mailbox setup");
  pd_check_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.st == FBN_ST_PREOP && req.valid && req.code == FBN_CODE_SAFEOP
    |=> (state_reg.st == FBN_ST_SAFEOP) == $past(pd_cfg_ok))
    else $error("safeop entry check wrong");
  input_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_reg.st == FBN_ST_SAFEOP) && $past(state_reg.st) == FBN_ST_PREOP
    |-> dpm_in == $past(phys_in) && ack)
    else $error("inputs not copied on safeop entry");
  outputs_off_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.st != FBN_ST_OP |-> phys_out == '0)
    else $error("outputs active outside op");
  op_outputs_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.st == FBN_ST_OP && $past(state_reg.st) == FBN_ST_OP
    |-> phys_out == $past(master_out))
    else $error("outputs do not follow master");
  boot_services_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.st == FBN_ST_BOOT |-> services == 4'b0100)
    else $error("wrong services in bootstrap");
  run_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.hs == FBN_HS_WAIT_OP && any_safeop |=> !main_program_run)
    else $error("program started with node in safeop");
  mon_limit_a: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.hs == FBN_HS_STARTUP && state_reg.mon_cnt == MW'(MON_CYCLES - 1)
    |=> host_req_op)
    else $error("monitoring time overrun");
endmodule : fbn_node
`default_nettype wire

// ==== fbn_pkg.sv ====
// package for the fieldbus node state machine: codes, timing, carrier types
`default_nettype none
package fbn_pkg;
  // state codes reported to the master
  localparam logic [7:0] FBN_CODE_ABSENT = 8'h00;
  localparam logic [7:0] FBN_CODE_INIT = 8'h01;
  localparam logic [7:0] FBN_CODE_PREOP = 8'h02;
  localparam logic [7:0] FBN_CODE_BOOT = 8'h03;
  localparam logic [7:0] FBN_CODE_SAFEOP = 8'h04;
  localparam logic [7:0] FBN_CODE_OP = 8'h08;
  localparam logic [7:0] FBN_CODE_UNCONF = 8'hFF;
  // emergency message codes
  localparam logic [7:0] FBN_EMCY_NONE = 8'h00;
  localparam logic [7:0] FBN_EMCY_ILLEGAL = 8'h11;
  localparam logic [7:0] FBN_EMCY_MBX_CFG = 8'h12;
  localparam logic [7:0] FBN_EMCY_PD_CFG = 8'h13;
  localparam logic [7:0] FBN_EMCY_DIAG = 8'h14;
  // start-up monitoring time of the host, milliseconds, and clock rate
  localparam int FBN_CLK_HZ = 10_000_000;
  localparam int FBN_MON_TIME_MS = 1000;
  localparam int FBN_MON_CYCLES = (FBN_MON_TIME_MS * (FBN_CLK_HZ / 1000));
  localparam int FBN_IO_W = 16;

  typedef enum logic [2:0] {
    FBN_ST_INIT,
    FBN_ST_PREOP,
    FBN_ST_BOOT,
    FBN_ST_SAFEOP,
    FBN_ST_OP
  } fbn_state_t;

  // service enables derived from the state
  typedef struct packed {
    logic mailbox_en;
    logic file_access_en;
    logic inputs_en;
    logic outputs_en;
  } fbn_services_t;

  // state request from the master
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } fbn_request_t;

  // emergency message toward the master
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] state_code;
  } fbn_emcy_t;

  typedef enum logic [1:0] {
    FBN_HS_STARTUP,
    FBN_HS_WAIT_OP,
    FBN_HS_RUN
  } fbn_host_t;
endpackage : fbn_pkg
`default_nettype wire

// ==== fbn_mst_model.sv ====
// behavioural master: issues state requests and owns the channel setup flags
`default_nettype none
module fbn_mst_model
  import fbn_pkg::*;
(
  input wire logic go,
  input wire logic [7:0] code,
  input wire logic mbx_setup,
  input wire logic pd_setup,
  output fbn_request_t req,
  output logic mbx_cfg_ok,
  output logic pd_cfg_ok
);
  // only this side asks for a state change, one pulse per request
  assign req = '{valid: go, code: code};
  // setup outcome is a level held until the master redoes the setup
  assign mbx_cfg_ok = mbx_setup;
  assign pd_cfg_ok = pd_setup;
endmodule : fbn_mst_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the fieldbus node state machine
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fbn_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic mbx;
    logic pd;
    logic ok;
    logic [7:0] st;
    logic [3:0] sv;
    logic [7:0] em;
  } fbn_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic [7:0] code = 8'h00;
  logic mbx_setup = 1'b0;
  logic pd_setup = 1'b0;
  logic present = 1'b1;
  logic configured = 1'b1;
  logic diag_event = 1'b0;
  logic [7:0] diag_code = 8'h00;
  logic [15:0] phys_in = 16'hA5C3;
  logic [15:0] master_out = 16'h3C5A;
  logic any_safeop = 1'b1;
  logic mandatory_ready = 1'b0;
  fbn_request_t req;
  logic mbx_cfg_ok, pd_cfg_ok, ack, error, host_req_op, main_program_run;
  logic [7:0] state_code;
  fbn_services_t services;
  fbn_emcy_t emcy;
  logic [15:0] dpm_in, phys_out;
  int num_errors = 0;
  int n_tests = 0;
  // code, mbx, pd, ok, state, {mbx,file,in,out}, emergency code
  fbn_row_t rows [12] = '{
    '{8'h04, 1'b1, 1'b1, 1'b0, 8'h01, 4'h0, 8'h11},
    '{8'h02, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, 8'h12},
    '{8'h02, 1'b1, 1'b1, 1'b1, 8'h02, 4'h8, 8'h00},
    '{8'h03, 1'b1, 1'b1, 1'b0, 8'h02, 4'h8, 8'h11},
    '{8'h04, 1'b1, 1'b0, 1'b0, 8'h02, 4'h8, 8'h13},
    '{8'h04, 1'b1, 1'b1, 1'b1, 8'h04, 4'hA, 8'h00},
    '{8'h08, 1'b1, 1'b1, 1'b1, 8'h08, 4'hB, 8'h00},
    '{8'h04, 1'b1, 1'b1, 1'b1, 8'h04, 4'hA, 8'h00},
    '{8'h02, 1'b1, 1'b1, 1'b1, 8'h02, 4'h8, 8'h00},
    '{8'h01, 1'b1, 1'b1, 1'b1, 8'h01, 4'h0, 8'h00},
    '{8'h03, 1'b1, 1'b1, 1'b1, 8'h03, 4'h4, 8'h00},
    '{8'h01, 1'b1, 1'b1, 1'b1, 8'h01, 4'h0, 8'h00}};
  fbn_mst_model master (.go(go), .code(code), .mbx_setup(mbx_setup), .pd_setup(pd_setup),
    .req(req), .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok));
  // short monitoring time keeps the start-up wait inside the run
  fbn_node #(.IO_W(16), .MON_CYCLES(16)) dut (.clk(clk), .rstn(rstn), .req(req),
    .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok), .station_present(present),
    .station_configured(configured), .diag_event(diag_event), .diag_code(diag_code),
    .phys_in(phys_in), .master_out(master_out), .mandatory_ready(mandatory_ready),
    .any_safeop(any_safeop), .state_code(state_code), .services(services), .ack(ack),
    .error(error), .emcy(emcy), .dpm_in(dpm_in), .phys_out(phys_out),
    .host_req_op(host_req_op), .main_program_run(main_program_run));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w
  task automatic close_out;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ticks
  // one request pulse; returns just after the edge that registers the answer
  task automatic request(input logic [7:0] c);
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask : request
  // watchdog sized well above the roughly 60 cycles the tests need
  initial
  begin
    #(100 * 3000);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
  initial
  begin
    #1;
    chk8(state_code, 8'h00);
    chk8({4'h0, services}, 8'h00);
    ticks(3);
    rstn <= 1'b1;
    ticks(3);
    chk8(state_code, 8'h01);
    chk8({7'h0, host_req_op}, 8'h00);
    $display("reset test done");
    // transition table: each row is a request, its answer and the services it leaves
    foreach (rows[i])
    begin
      @(posedge clk);
      go <= 1'b1;
      code <= rows[i].code;
      mbx_setup <= rows[i].mbx;
      pd_setup <= rows[i].pd;
      @(posedge clk);
      go <= 1'b0;
      #1;
      chk8({7'h0, ack}, {7'h0, rows[i].ok});
      chk8({7'h0, error}, {7'h0, ~rows[i].ok});
      chk8(state_code, rows[i].st);
      chk8({4'h0, services}, {4'h0, rows[i].sv});
      chk_w(phys_out, (rows[i].st == 8'h08) ? master_out : 16'h0000);
      if (rows[i].st == 8'h04 || rows[i].st == 8'h08)
        chk_w(dpm_in, phys_in);
      chk8({7'h0, emcy.valid}, {7'h0, ~rows[i].ok});
      if (!rows[i].ok)
        chk8(emcy.code, rows[i].em);
      if (!rows[i].ok)
        chk8(emcy.state_code, rows[i].st);
      $display("row %0d done", i);
    end
    // host start-up: monitoring time expired long ago, program held by safeop nodes
    chk8({7'h0, host_req_op}, 8'h01);
    chk8({7'h0, main_program_run}, 8'h00);
    any_safeop <= 1'b0;
    ticks(3);
    chk8({7'h0, main_program_run}, 8'h01);
    $display("host test done");
    // diagnostic event becomes an emergency
    @(posedge clk);
    diag_event <= 1'b1;
    diag_code <= 8'h14;
    @(posedge clk);
    diag_event <= 1'b0;
    #1;
    chk8({7'h0, emcy.valid}, 8'h01);
    chk8(emcy.code, 8'h14);
    chk8(emcy.state_code, 8'h01);
    $display("diag test done");
    // station absent and unconfigured codes via the synchronised pins
    present <= 1'b0;
    ticks(4);
    chk8(state_code, 8'h00);
    present <= 1'b1;
    configured <= 1'b0;
    ticks(4);
    chk8(state_code, 8'hFF);
    configured <= 1'b1;
    ticks(4);
    chk8(state_code, 8'h01);
    $display("station test done");
    // inputs tracked every cycle in safeop, outputs follow the master in op
    request(8'h02);
    request(8'h04);
    phys_in <= 16'h1234;
    ticks(2);
    chk_w(dpm_in, 16'h1234);
    chk_w(phys_out, 16'h0000);
    request(8'h08);
    master_out <= 16'h0F0F;
    ticks(1);
    chk_w(phys_out, 16'h0F0F);
    $display("data path test done");
    // reset in mid-run from op, with mandatory nodes ready at once
    mandatory_ready <= 1'b1;
    rstn <= 1'b0;
    ticks(3);
    chk8({4'h0, services}, 8'h00);
    chk_w(phys_out, 16'h0000);
    chk8(state_code, 8'h00);
    rstn <= 1'b1;
    ticks(1);
    chk8({7'h0, host_req_op}, 8'h01);
    chk8({7'h0, main_program_run}, 8'h00);
    ticks(2);
    chk8(state_code, 8'h01);
    chk8({7'h0, main_program_run}, 8'h01);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
